// ---- rtl/mbo_pkg.sv ----
/*
  shared constants and types of the memory barrier ordering block.
  assumes nothing of its surroundings; imported by every design file.
*/
package mbo_pkg;

  // barrier type field position in the barrier instruction
  localparam int unsigned STYPE_LSB = 6;
  localparam int unsigned STYPE_MSB = 10;
  localparam int unsigned STYPE_W   = STYPE_MSB - STYPE_LSB + 1;
  localparam int unsigned INSTR_W   = 32;

  // barrier type codes
  localparam logic [4:0] ST_COMPLETE   = 5'h00;
  localparam logic [4:0] ST_WRITE      = 5'h04;
  localparam logic [4:0] ST_FULL_ORDER = 5'h10;
  localparam logic [4:0] ST_ACQUIRE    = 5'h11;
  localparam logic [4:0] ST_RELEASE    = 5'h12;
  localparam logic [4:0] ST_READ       = 5'h13;

  // outstanding-operation tracker indices
  localparam int unsigned TRK_LD_OP   = 0;
  localparam int unsigned TRK_ST_OP   = 1;
  localparam int unsigned TRK_LD_DONE = 2;
  localparam int unsigned TRK_ST_GP   = 3;
  localparam int unsigned TRK_EXT     = 4;
  localparam int unsigned TRK_NUM     = 5;

  localparam int unsigned CNT_W_DEF = 6;

  typedef enum logic [1:0] {
    OP_LOAD,
    OP_STORE,
    OP_MAINT,
    OP_BARRIER
  } mbo_op_t;

  // which older ops must drain and which younger ops are held
  typedef struct packed {
    logic complete;
    logic old_ld;
    logic old_st;
    logic yng_ld;
    logic yng_st;
  } mbo_sel_t;

  localparam mbo_sel_t SEL_NONE = 5'h00;
  localparam mbo_sel_t SEL_FULL = 5'h1F;

endpackage : mbo_pkg

// ---- rtl/mbo_sel_if.sv ----
/*
  carrier between the barrier top and its type decoder.
  assumes mbo_pkg is compiled first.
*/
`timescale 1ns/1ps
interface mbo_sel_if
  import mbo_pkg::*;
();
  logic [STYPE_W-1:0] stype;
  mbo_sel_t           sel;

  modport dec  (input stype, output sel);
  modport user (output stype, input sel);
endinterface : mbo_sel_if

// ---- rtl/mbo_decode.sv ----
/*
  barrier type decoder: five-bit type code to drain and hold selection.
  assumes the code is already extracted from the instruction.
*/
`timescale 1ns/1ps
module mbo_decode
  import mbo_pkg::*;
#(
  parameter bit OPT_EN = 1'b1
) (
  mbo_sel_if.dec sif
);

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    sif.sel = SEL_FULL;
    if (OPT_EN) begin
      case (sif.stype)
        ST_WRITE:      sif.sel = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
        ST_FULL_ORDER: sif.sel = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
        ST_ACQUIRE:    sif.sel = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
        ST_RELEASE:    sif.sel = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
        ST_READ:       sif.sel = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
        // vendor and reserved codes fall back to the full barrier
        default:       sif.sel = SEL_FULL;
      endcase
    end
  end

endmodule : mbo_decode

// ---- rtl/mbo_track.sv ----
/*
  up/down counter of outstanding memory operations of one class.
  assumes dec pulses never exceed the number of prior inc pulses.
*/
`timescale 1ns/1ps
module mbo_track
  import mbo_pkg::*;
#(
  parameter int unsigned CNT_W = CNT_W_DEF
) (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic inc,
  input  wire logic dec,
  output logic      zero,
  output logic      full
);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
  } mbo_trk_t;

  mbo_trk_t trk_reg;
  mbo_trk_t trk_next;

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    trk_next = trk_reg;
    if (inc && !(dec && trk_reg.cnt != '0))
      trk_next.cnt = trk_reg.cnt + 1'b1;
    else if (dec && !inc && trk_reg.cnt != '0)
      trk_next.cnt = trk_reg.cnt - 1'b1;
  end

  always_ff @(posedge clk) begin
    if (reset)
      trk_reg <= '0;
    else
      trk_reg <= trk_next;
  end

  assign zero = (trk_reg.cnt == '0);
  assign full = (trk_reg.cnt == '1);

endmodule : mbo_track

// ---- rtl/mbo_barrier.sv ----
/*
  memory barrier ordering control between the issue pipeline and the
  load/store datapath. ops and barriers arrive in program order on one
  port; younger ops held by an active barrier wait in a one-entry slot.
  assumes the datapath pulses its progress signals once per sync op it
  was handed, and the external memory side honours ext_hold.
*/
//
// Overview of operation
// - only uncached or coherent-cached ops are ordered
// - completion: older ops complete before younger start
// - load done on writeback, store done when visible
// - instruction fetches are never ordered here
// - type zero is mandatory full completion barrier
// - unassigned nonzero types act as type zero
// - ordering: older reach ordering point first
// - older external requests globally performed first
// - ordering barrier skips waiting for completion
// - cache ops and prefetches count as both
// - barrier type is instruction bits ten to six
// - type 0x4 orders stores before stores
// - type 0x10 orders everything before everything
// - type 0x11 orders loads before everything
// - type 0x12 orders everything before stores
// - type 0x13 orders loads before loads
// - vendor and reserved codes decode as fallback
// - sync flag marks shared uncached/coherent access
// - global performance reported by datapath pulses
//
`timescale 1ns/1ps
module mbo_barrier
  import mbo_pkg::*;
#(
  parameter int unsigned CNT_W  = CNT_W_DEF,
  parameter bit          OPT_EN = 1'b1
) (
  input  wire logic               clk,
  input  wire logic               reset,
  input  wire logic               in_valid,
  input  wire logic [1:0]         in_kind,
  input  wire logic               in_sync,
  input  wire logic [INSTR_W-1:0] in_instr,
  output logic                    in_ready,
  output logic                    lsd_valid,
  output logic [1:0]              lsd_kind,
  output logic                    lsd_sync,
  input  wire logic               lsd_ready,
  input  wire logic               lsd_ld_ordered,
  input  wire logic               lsd_st_ordered,
  input  wire logic               lsd_ld_done,
  input  wire logic               lsd_st_gp,
  input  wire logic               ext_req_sent,
  input  wire logic               ext_req_gp,
  output logic                    ext_hold,
  output logic                    bar_busy,
  output logic                    bar_done,
  output logic [STYPE_W-1:0]      bar_type
);

  // a one-bit counter would already read saturated with a single op outstanding
  if (CNT_W < 2) begin : g_cnt_w_check
    $error("mbo_barrier: CNT_W must be at least 2");
  end

  typedef enum logic {
    S_IDLE,
    S_DRAIN
  } mbo_state_t;

  typedef struct packed {
    mbo_state_t         state;
    logic               slot_full;
    mbo_op_t            slot_kind;
    logic               slot_sync;
    logic [STYPE_W-1:0] slot_stype;
    mbo_sel_t           sel;
    logic [STYPE_W-1:0] bar_type;
    logic               in_ready;
    logic               lsd_valid;
    logic               ext_hold;
    logic               bar_done;
    logic               bar_busy;
  } mbo_ctl_t;

  mbo_ctl_t ctl_reg;
  mbo_ctl_t ctl_next;

  logic [TRK_NUM-1:0] trk_inc;
  logic [TRK_NUM-1:0] trk_dec;
  logic [TRK_NUM-1:0] trk_zero;
  logic [TRK_NUM-1:0] trk_full;
  logic               issue;

  mbo_sel_if sif ();

  ////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic ld_like(input mbo_op_t k);
    ld_like = (k == OP_LOAD) || (k == OP_MAINT);
  endfunction : ld_like

  function automatic logic st_like(input mbo_op_t k);
    st_like = (k == OP_STORE) || (k == OP_MAINT);
  endfunction : st_like

  // younger sync op of a selected class waits while a barrier drains
  function automatic logic held(input mbo_ctl_t c, input logic [TRK_NUM-1:0] f);
    logic by_bar;
    logic by_cnt;
    by_bar = (c.state == S_DRAIN) && c.slot_sync &&
             ((ld_like(c.slot_kind) && c.sel.yng_ld) ||
              (st_like(c.slot_kind) && c.sel.yng_st));
    // counter saturation would lose track of older ops, so stall
    by_cnt = c.slot_sync &&
             ((ld_like(c.slot_kind) && (f[TRK_LD_OP] || f[TRK_LD_DONE])) ||
              (st_like(c.slot_kind) && (f[TRK_ST_OP] || f[TRK_ST_GP])));
    held = by_bar || by_cnt;
  endfunction : held

  // drain condition of the active barrier
  function automatic logic met(input mbo_sel_t s, input logic [TRK_NUM-1:0] z);
    logic ld_ok;
    logic st_ok;
    ld_ok = !s.old_ld || (z[TRK_LD_OP] &&
            (!s.complete || z[TRK_LD_DONE]));
    st_ok = !s.old_st || (z[TRK_ST_OP] &&
            (!s.complete || z[TRK_ST_GP]));
    met = ld_ok && st_ok;
  endfunction : met

  ////////////////////////////////////////////////////////////////////////
  // type decode

  assign sif.stype = ctl_reg.slot_stype;

  mbo_decode #(
    .OPT_EN (OPT_EN)
  ) u_decode (
    .sif (sif.dec)
  );

  ////////////////////////////////////////////////////////////////////////
  // outstanding trackers; load/store ones count only sync ops, the external one every ext_req_sent

  assign issue = ctl_reg.lsd_valid && lsd_ready;

  always_comb begin
    trk_inc              = '0;
    trk_inc[TRK_LD_OP]   = issue && ctl_reg.slot_sync && ld_like(ctl_reg.slot_kind);
    trk_inc[TRK_LD_DONE] = trk_inc[TRK_LD_OP];
    trk_inc[TRK_ST_OP]   = issue && ctl_reg.slot_sync && st_like(ctl_reg.slot_kind);
    trk_inc[TRK_ST_GP]   = trk_inc[TRK_ST_OP];
    trk_inc[TRK_EXT]     = ext_req_sent;
    trk_dec              = '0;
    trk_dec[TRK_LD_OP]   = lsd_ld_ordered;
    trk_dec[TRK_ST_OP]   = lsd_st_ordered;
    trk_dec[TRK_LD_DONE] = lsd_ld_done;
    trk_dec[TRK_ST_GP]   = lsd_st_gp;
    trk_dec[TRK_EXT]     = ext_req_gp;
  end

  // draining to zero also waits on younger unselected ops; safe but
  // may stall a little longer than strictly necessary
  for (genvar i = 0; i < TRK_NUM; i++) begin : g_trk
    mbo_track #(
      .CNT_W (CNT_W)
    ) u_track (
      .clk   (clk),
      .reset (reset),
      .inc   (trk_inc[i]),
      .dec   (trk_dec[i]),
      .zero  (trk_zero[i]),
      .full  (trk_full[i])
    );
  end

  ////////////////////////////////////////////////////////////////////////
  // control

  always_comb begin
    ctl_next          = ctl_reg;
    ctl_next.bar_done = 1'b0;

    if (issue)
      ctl_next.slot_full = 1'b0;

    // slot is empty whenever in_ready is high
    if (ctl_reg.in_ready && in_valid) begin
      ctl_next.slot_full  = 1'b1;
      ctl_next.slot_kind  = mbo_op_t'(in_kind);
      ctl_next.slot_sync  = in_sync;
      ctl_next.slot_stype = in_instr[STYPE_MSB:STYPE_LSB];
    end

    // older external requests drained: younger may go out again
    if (ctl_reg.ext_hold && trk_zero[TRK_EXT])
      ctl_next.ext_hold = 1'b0;

    case (ctl_reg.state)
      S_IDLE: begin
        if (ctl_reg.slot_full && ctl_reg.slot_kind == OP_BARRIER) begin
          ctl_next.sel       = sif.sel;
          ctl_next.bar_type  = ctl_reg.slot_stype;
          ctl_next.slot_full = 1'b0;
          ctl_next.state     = S_DRAIN;
        end
      end
      S_DRAIN: begin
        if (met(ctl_reg.sel, trk_zero)) begin
          ctl_next.state    = S_IDLE;
          ctl_next.bar_done = 1'b1;
          ctl_next.sel      = SEL_NONE;
          // ordering barrier: younger external requests wait behind older
          if (!ctl_reg.sel.complete && !trk_zero[TRK_EXT])
            ctl_next.ext_hold = 1'b1;
        end
      end
      default: begin
        ctl_next.state = S_IDLE;
      end
    endcase

    // a barrier never reaches the datapath; fetches never pass here
    ctl_next.lsd_valid = ctl_next.slot_full &&
                         ctl_next.slot_kind != OP_BARRIER &&
                         !held(ctl_next, trk_full);
    ctl_next.in_ready  = !ctl_next.slot_full;
    ctl_next.bar_busy  = (ctl_next.state == S_DRAIN);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      ctl_reg          <= '0;
      ctl_reg.state    <= S_IDLE;
      ctl_reg.sel      <= SEL_NONE;
      ctl_reg.in_ready <= 1'b0;
    end else begin
      ctl_reg <= ctl_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs straight from the control register

  assign in_ready  = ctl_reg.in_ready;
  assign lsd_valid = ctl_reg.lsd_valid;
  assign lsd_kind  = ctl_reg.slot_kind;
  assign lsd_sync  = ctl_reg.slot_sync;
  assign ext_hold  = ctl_reg.ext_hold;
  assign bar_busy  = ctl_reg.bar_busy;
  assign bar_done  = ctl_reg.bar_done;
  assign bar_type  = ctl_reg.bar_type;

endmodule : mbo_barrier

// ---- test/mbo_barrier_assertions.sv ----
/*
  port checker of mbo_barrier, bound to every instance.
  assumes OPT_EN at its default and one barrier draining at a time.
*/
`timescale 1ns/1ps
module mbo_barrier_assertions
  import mbo_pkg::*;
(
  input logic               clk,
  input logic               reset,
  input logic               in_valid,
  input logic [1:0]         in_kind,
  input logic               in_sync,
  input logic [INSTR_W-1:0] in_instr,
  input logic               in_ready,
  input logic               lsd_valid,
  input logic [1:0]         lsd_kind,
  input logic               lsd_sync,
  input logic               lsd_ready,
  input logic               lsd_ld_ordered,
  input logic               lsd_st_ordered,
  input logic               lsd_ld_done,
  input logic               lsd_st_gp,
  input logic               ext_req_sent,
  input logic               ext_req_gp,
  input logic               ext_hold,
  input logic               bar_busy,
  input logic               bar_done,
  input logic [STYPE_W-1:0] bar_type
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  logic [7:0] ord_ld, ord_st, cmp_ld, cmp_st, ext_n;
  mbo_sel_t   s;
  wire take = in_valid && in_ready;
  wire go   = lsd_valid && lsd_ready && lsd_sync;
  wire gl   = go && lsd_kind != 2'h1;
  wire gs   = go && lsd_kind != 2'h0;
  //////////////////////////////////////////////////
  always_comb begin
    case (bar_type)
      ST_WRITE:      s = 5'h05;
      ST_FULL_ORDER: s = 5'h0F;
      ST_ACQUIRE:    s = 5'h0B;
      ST_RELEASE:    s = 5'h0D;
      ST_READ:       s = 5'h0A;
      default:       s = SEL_FULL;
    endcase
  end
  // own outstanding counts, kept apart from the design's trackers
  always_ff @(posedge clk) begin
    if (reset) begin
      {ord_ld, ord_st, cmp_ld, cmp_st, ext_n} <= '0;
    end else begin
      ord_ld <= ord_ld + 8'(gl) - 8'(lsd_ld_ordered);
      ord_st <= ord_st + 8'(gs) - 8'(lsd_st_ordered);
      cmp_ld <= cmp_ld + 8'(gl) - 8'(lsd_ld_done);
      cmp_st <= cmp_st + 8'(gs) - 8'(lsd_st_gp);
      ext_n  <= ext_n + 8'(ext_req_sent) - 8'(ext_req_gp);
    end
  end
  sequence s_bar_take;
    take && in_kind == 2'h3 && !bar_busy && !bar_done;
  endsequence
  sequence s_bar_end;
    !bar_busy && $past(bar_busy) ##1 !bar_done;
  endsequence
  a_slot_refuse: assert property (take |=> !in_ready)
    else $error("slot took a second request");
  a_free_pass: assert property (
    take && in_kind != 2'h3 && !in_sync |=> lsd_valid && lsd_kind == $past(in_kind))
    else $error("non-sync op delayed");
  a_offer_stable: assert property (
    lsd_valid && !lsd_ready |=> lsd_valid && $stable(lsd_kind) && $stable(lsd_sync))
    else $error("offer changed before taken");
  a_young_held: assert property (
    bar_busy && lsd_valid && lsd_sync
    |-> !((s.yng_ld && lsd_kind != 2'h1) || (s.yng_st && lsd_kind != 2'h0)))
    else $error("younger op passed barrier");
  // counts as seen at the edge that ended the drain, not one later
  a_drain_order: assert property (
    bar_done |-> (!s.old_ld || $past(ord_ld) == 8'h00) &&
                 (!s.old_st || $past(ord_st) == 8'h00))
    else $error("barrier ended before ordering");
  a_drain_complete: assert property (
    bar_done && s.complete |-> $past({cmp_ld, cmp_st, ord_ld, ord_st}) == 32'h0000_0000)
    else $error("barrier ended before completion");
  a_done_pulse: assert property (bar_done |-> s_bar_end)
    else $error("done pulse malformed");
  a_ext_release: assert property ($fell(ext_hold) |-> ext_n == 8'h00)
    else $error("ext hold dropped early");
  a_type_field: assert property (
    s_bar_take |-> ##2 bar_busy && bar_type == $past(in_instr[STYPE_MSB:STYPE_LSB], 2))
    else $error("barrier type not taken");
endmodule : mbo_barrier_assertions

bind mbo_barrier mbo_barrier_assertions chk_u (.*);

// ---- test/mbo_lsd_model.sv ----
/*
  behavioural load/store datapath and memory side.
  assumes one sync op taken at most every two cycles.
*/
`timescale 1ns/1ps
module mbo_lsd_model #(
  parameter int ORD_DLY  = 10,
  parameter int DONE_DLY = 30
) (
  input  logic       clk,
  input  logic       reset,
  input  logic       lsd_valid,
  input  logic [1:0] lsd_kind,
  input  logic       lsd_sync,
  input  logic       ext_hold,
  output logic       lsd_ready,
  output logic       lsd_ld_ordered = 1'b0,
  output logic       lsd_st_ordered = 1'b0,
  output logic       lsd_ld_done    = 1'b0,
  output logic       lsd_st_gp      = 1'b0,
  output logic       ext_req_sent   = 1'b0,
  output logic       ext_req_gp     = 1'b0,
  output int         pend           = 0
);
  logic [1:0] ph = 2'h0;
  //////////////////////////////////////////////////
  // stalls one cycle in four so held offers occur
  always @(posedge clk) ph <= ph + 2'h1;
  assign lsd_ready = (ph != 2'h3);
  always @(posedge clk) begin
    if (!reset && lsd_valid && lsd_ready && lsd_sync) begin
      fork
        automatic logic l = (lsd_kind != 2'h1);
        automatic logic s = (lsd_kind != 2'h0);
        automatic logic x = 1'b0;
        begin
          pend++;
          repeat (ORD_DLY) @(posedge clk);
          x = !ext_hold;
          {lsd_ld_ordered, lsd_st_ordered, ext_req_sent} <= {l, s, x};
          @(posedge clk);
          {lsd_ld_ordered, lsd_st_ordered, ext_req_sent} <= 3'h0;
          repeat (DONE_DLY - ORD_DLY - 1) @(posedge clk);
          {lsd_ld_done, lsd_st_gp, ext_req_gp} <= {l, s, x};
          @(posedge clk);
          {lsd_ld_done, lsd_st_gp, ext_req_gp} <= 3'h0;
          pend--;
        end
      join_none
    end
  end
endmodule : mbo_lsd_model

// ---- test/mbo_barrier_tb_top.sv ----
/*
  self-checking bench of mbo_barrier with the datapath model.
  assumes the checker is bound through its own file.
*/
`timescale 1ns/1ps
module mbo_barrier_tb_top;
  import mbo_pkg::*;
  logic clk = 1'b0, reset = 1'b1, in_valid = 1'b0, in_sync = 1'b0;
  logic [1:0] in_kind = 2'h0;
  logic [INSTR_W-1:0] in_instr = 32'h0000_0000;
  logic in_ready, lsd_valid, lsd_sync, lsd_ready, lsd_ld_ordered, lsd_st_ordered;
  logic lsd_ld_done, lsd_st_gp, ext_req_sent, ext_req_gp, ext_hold, bar_busy, bar_done;
  logic [1:0] lsd_kind;
  logic [STYPE_W-1:0] bar_type;
  logic saw_o = 1'b0, saw_d = 1'b0, clr = 1'b0, tk_o, tk_d;
  int pend, failures = 0, tests_run = 0;
  //////////////////////////////////////////////////
  always #2.5 clk = ~clk;
  mbo_barrier dut_u (.*);
  mbo_lsd_model lsd_u (.*);
  // progress seen before each datapath take
  always @(posedge clk) begin
    if (clr) {saw_o, saw_d} <= 2'h0;
    if (lsd_ld_ordered || lsd_st_ordered) saw_o <= 1'b1;
    if (lsd_ld_done || lsd_st_gp) saw_d <= 1'b1;
    if (lsd_valid && lsd_ready) {tk_o, tk_d} <= {saw_o, saw_d};
  end
  task automatic check(input logic [4:0] got, input logic [4:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check
  task automatic issue(input logic [1:0] k, input logic s, input logic [4:0] c);
    in_valid = 1'b1;
    in_kind = k;
    in_sync = s;
    in_instr[STYPE_MSB:STYPE_LSB] = c;
    do @(posedge clk); while (in_ready !== 1'b1);
    #1 in_valid = 1'b0;
    @(posedge clk);
    #1;
  endtask : issue
  // older sync op, barrier, younger op; e is expected {ordered, done}
  task automatic bar_case(input logic [4:0] c, input logic [1:0] ok, input logic [1:0] yk,
                          input logic ys, input logic [1:0] e);
    int n;
    n = 0;
    issue(ok, 1'b1, 5'h00);
    clr = 1'b1;
    issue(2'h3, 1'b0, c);
    clr = 1'b0;
    issue(yk, ys, 5'h00);
    // a released younger op is still offered when the drain ends
    while ((pend != 0 || bar_busy !== 1'b0 || lsd_valid !== 1'b0) && n < 300) begin
      @(posedge clk);
      #1 n++;
    end
    if (n >= 300) begin
      failures++;
      $display("MISMATCH %0t drain timed out", $time);
    end
    check({3'h0, tk_o, tk_d}, {3'h0, e}, "younger release");
    check(bar_type, c, "barrier type");
    $display("case type %h done", c);
  endtask : bar_case
  task automatic complete_run;
    $display("tests_run %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run
  initial begin
    #50000;
    failures++;
    $display("MISMATCH %0t watchdog expired", $time);
    complete_run();
  end
  initial begin
    repeat (4) @(posedge clk);
    #1 check({4'h0, in_ready}, 5'h00, "ready in reset");
    reset = 1'b0;
    @(posedge clk);
    #1 check({4'h0, in_ready}, 5'h01, "ready after reset");
    bar_case(5'h00, 2'h0, 2'h0, 1'b1, 2'h3);
    bar_case(5'h00, 2'h0, 2'h0, 1'b0, 2'h0);
    bar_case(5'h01, 2'h1, 2'h0, 1'b1, 2'h3);
    bar_case(5'h0F, 2'h0, 2'h1, 1'b1, 2'h3);
    bar_case(5'h14, 2'h1, 2'h1, 1'b1, 2'h3);
    bar_case(5'h1F, 2'h2, 2'h0, 1'b1, 2'h3);
    bar_case(5'h04, 2'h1, 2'h1, 1'b1, 2'h2);
    bar_case(5'h04, 2'h1, 2'h0, 1'b1, 2'h0);
    bar_case(5'h10, 2'h0, 2'h1, 1'b1, 2'h2);
    bar_case(5'h11, 2'h0, 2'h1, 1'b1, 2'h2);
    bar_case(5'h12, 2'h1, 2'h0, 1'b1, 2'h0);
    bar_case(5'h12, 2'h0, 2'h1, 1'b1, 2'h2);
    bar_case(5'h13, 2'h0, 2'h0, 1'b1, 2'h2);
    bar_case(5'h13, 2'h0, 2'h1, 1'b1, 2'h0);
    bar_case(5'h13, 2'h2, 2'h0, 1'b1, 2'h2);
    complete_run();
  end
endmodule : mbo_barrier_tb_top
